// ===== irt_pkg.sv
/*
 Constants for the infrared counter/timer pair: register indices, field
 positions, reset values and mode codes.
 Assumes an 8-bit register port with byte-wide data and word indices.
*/
package irt_pkg;
	// ------------------------------------------------------------------
	// Register indices
	// ------------------------------------------------------------------
	localparam logic [3:0] IRT_A_BCTL = 4'h0;
	localparam logic [3:0] IRT_A_SCTL = 4'h1;
	localparam logic [3:0] IRT_A_WCTL = 4'h2;
	localparam logic [3:0] IRT_A_BLO  = 4'h4;
	localparam logic [3:0] IRT_A_BHI  = 4'h5;
	localparam logic [3:0] IRT_A_WLO  = 4'h6;
	localparam logic [3:0] IRT_A_WHI  = 4'h7;
	localparam logic [3:0] IRT_A_WCL  = 4'h8;
	localparam logic [3:0] IRT_A_WCU  = 4'h9;
	localparam logic [3:0] IRT_A_BCL  = 4'ha;
	localparam logic [3:0] IRT_A_BCH  = 4'hb;

	// ------------------------------------------------------------------
	// Field positions (timer control and shared control)
	// ------------------------------------------------------------------
	localparam int IRT_B_EN    = 7;
	localparam int IRT_B_SUB   = 6;
	localparam int IRT_B_TO    = 5;
	localparam int IRT_B_CLKH  = 4;
	localparam int IRT_B_CLKL  = 3;
	localparam int IRT_B_CIE   = 2;
	localparam int IRT_B_TIE   = 1;
	localparam int IRT_B_PIN   = 0;
	localparam int IRT_B_MODE  = 7;
	localparam int IRT_B_INSEL = 6;
	localparam int IRT_B_F1H   = 5;
	localparam int IRT_B_F1L   = 4;
	localparam int IRT_B_F2H   = 3;
	localparam int IRT_B_F2L   = 2;
	localparam int IRT_B_RISE  = 1;
	localparam int IRT_B_FALL  = 0;

	// ------------------------------------------------------------------
	// Values and codes
	// ------------------------------------------------------------------
	localparam logic [7:0]  IRT_RST8  = 8'h00;
	localparam logic [7:0]  IRT_FF8   = 8'hff;
	localparam logic [15:0] IRT_FF16  = 16'hffff;
	localparam logic [7:0]  IRT_ONE8  = 8'h01;
	localparam logic [15:0] IRT_ONE16 = 16'h0001;
	localparam logic [1:0]  IRT_SUB_NORM = 2'h0;
	localparam logic [1:0]  IRT_SUB_PP   = 2'h1;
	localparam logic [1:0]  IRT_SUB_F0   = 2'h3;
	localparam logic [1:0]  IRT_EDG_FALL = 2'h0;
	localparam logic [1:0]  IRT_EDG_RISE = 2'h1;
	localparam logic [1:0]  IRT_EDG_BOTH = 2'h2;
	localparam logic [4:0]  IRT_FLT_4  = 5'h04;
	localparam logic [4:0]  IRT_FLT_8  = 5'h08;
	localparam logic [4:0]  IRT_FLT_16 = 5'h10;
	localparam logic [2:0]  IRT_DIV_MAX = 3'h7;
endpackage

// ===== irt_rx_model.sv
/*
 Receiver model: drives the demodulator input with timed levels.
 Assumes callers enter send just after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module irt_rx_model (
	input  wire logic clk,
	output var  logic line
);
	// ----------------
	// Line driver
	// ----------------
	// Rests low so the first pulse starts with a rising edge
	initial line = 1'b0;

	// Short holds make glitches for the input filter to reject
	task automatic send(input logic lvl, input int n);
		line <= lvl;
		repeat (n) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// ===== irt_tb.sv
/*
 Self-checking bench for the counter/timer pair and receiver model.
 Assumes read data stand one clock after the read strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
	import irt_pkg::*;
;
	// ----------------
	// Stimulus and wiring
	// ----------------
	logic       clk = 1'b0;
	logic       rst_b = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic       in_b = 1'b0;
	logic       byte_po = 1'b0;
	logic       word_po = 1'b0;
	logic       comb_po = 1'b0;
	wire logic  in_a;
	wire logic [7:0] rdata;
	wire logic  byte_pin, word_output_pin, comb_pin, byte_irq, word_irq;
	int         mismatches = 0;
	int         checked = 0;
	int         seed = 13;
	int         nb = 0;
	int         n, i;
	int         q[$];
	logic [7:0] v;

	always #12.5 clk = ~clk;

	// Unused port values churn so a stuck route shows up
	always @(posedge clk) begin
		{byte_po, word_po, comb_po, in_b} <= 4'($random(seed));
		if (byte_irq === 1'b1) nb <= nb + 1;
	end

	irt_timer dut (.clk(clk), .rst_b(rst_b), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .in_a(in_a),
		.in_b(in_b), .byte_port_out(byte_po), .word_port_out(word_po),
		.comb_port_out(comb_po), .byte_pin(byte_pin),
		.word_output_pin(word_output_pin), .comb_pin(comb_pin),
		.byte_irq(byte_irq), .word_irq(word_irq));
	irt_rx_model rx (.clk(clk), .line(in_a));

	// ----------------
	// Tasks
	// ----------------
	task automatic chk(input string nm, input logic [15:0] s, e);
		checked++;
		if (s !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Spans carry a few clocks of pipeline slack
	task automatic near(input string nm, input logic [15:0] s,
		input int e, t);
		chk(nm, s, (!$isunknown(s) && s + t > e && s < e + t) ? s : 16'(e));
	endtask
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] d;
		rreg(a, d);
		chk($sformatf("reg %h", a), d, e);
	endtask
	task automatic wirq(input bit w, output int k);
		k = 0;
		do begin
			@(posedge clk);
			#1 k++;
		end while ((w ? word_irq : byte_irq) !== 1'b1 && k < 3000);
		if (k >= 3000) mismatches++;
	endtask
	task automatic close_out();
		if (mismatches == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ----------------
	// Sequence
	// ----------------
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		close_out();
	end

	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		for (i = 0; i < 16; i++) rchk(4'(i), 8'h00);
		for (i = 4; i < 8; i++) begin
			v = 8'($random(seed));
			wreg(4'(i), v);
			rchk(4'(i), v);
		end
		// Word single pass at each divide, then flag clearing
		wreg(IRT_A_SCTL, 8'h00);
		wreg(IRT_A_WCTL, 8'h01);
		for (i = 0; i < 4; i++) begin
			wreg(IRT_A_WLO, 8'h14);
			wreg(IRT_A_WHI, 8'h00);
			v = 8'h43 | 8'(i << 3);
			wreg(IRT_A_WCTL, v | 8'h80);
			wirq(1, n);
			near("word span", 16'(n), 20 << i, (1 << i) + 4);
			// Pin lags the request by one clock
			@(posedge clk);
			#1;
			chk("word pin", word_output_pin, 1'b1);
			rchk(IRT_A_WCTL, v | 8'h20);
			wreg(IRT_A_WCTL, v);
			rchk(IRT_A_WCTL, v | 8'h20);
			wreg(IRT_A_WCTL, v | 8'h20);
			rchk(IRT_A_WCTL, v);
		end
		// Byte count of zero wraps and times out after 256 clocks
		wreg(IRT_A_BLO, 8'h00);
		wreg(IRT_A_BCTL, 8'hc3);
		wirq(0, n);
		near("byte wrap", 16'(n), 256, 4);
		@(posedge clk);
		#1;
		chk("byte pin", byte_pin, 1'b1);
		rchk(IRT_A_BCTL, 8'h63);
		wreg(IRT_A_BCTL, 8'h23);
		// Modulo-N, high hold rewritten mid-run
		wreg(IRT_A_BLO, 8'h0a);
		wreg(IRT_A_BHI, 8'h09);
		wreg(IRT_A_BCTL, 8'h83);
		wirq(0, n);
		wirq(0, n);
		near("byte cycle", 16'(n), 19, 3);
		wreg(IRT_A_BHI, 8'h03);
		wirq(0, n);
		wirq(0, n);
		near("byte cycle", 16'(n), 13, 3);
		wreg(IRT_A_BCTL, 8'h03);
		wreg(IRT_A_BCTL, 8'h23);
		// Ping-pong: byte low phase of 10 hands over to a word count of 20
		wreg(IRT_A_SCTL, 8'h04);
		wreg(IRT_A_WCTL, 8'h43);
		wreg(IRT_A_BCTL, 8'hc3);
		wirq(1, n);
		near("pp first", 16'(n), 30, 4);
		wirq(1, n);
		near("pp cycle", 16'(n), 30, 4);
		wreg(IRT_A_SCTL, 8'h00);
		wirq(0, n);
		repeat (40) @(posedge clk);
		rchk(IRT_A_BCTL, 8'h63);
		rchk(IRT_A_WCTL, 8'h63);
		// Demodulation on both edges, no filter
		for (i = 4; i < 8; i++) wreg(4'(i), 8'hff);
		wreg(IRT_A_SCTL, 8'ha0);
		wreg(IRT_A_BCTL, 8'h84);
		wreg(IRT_A_WCTL, 8'h84);
		nb = 0;
		q = {30, 40, 50};
		foreach (q[k]) rx.send(1'(k % 2 == 0), q[k]);
		rreg(IRT_A_BCH, v);
		near("byte cap high", v, q[0], 3);
		rreg(IRT_A_BCL, v);
		near("byte cap low", v, q[1], 3);
		rreg(IRT_A_WCL, v);
		near("word cap", v, q[1], 3);
		rchk(IRT_A_WCU, 8'h00);
		rchk(IRT_A_SCTL, 8'ha3);
		chk("edge irqs", 16'(nb), 16'h2);
		wreg(IRT_A_SCTL, 8'ha1);
		rchk(IRT_A_SCTL, 8'ha2);
		// Filter of four clocks drops a two-clock glitch
		wreg(IRT_A_SCTL, 8'ha6);
		rx.send(1'b0, 2);
		rx.send(1'b1, 30);
		rchk(IRT_A_SCTL, 8'ha4);
		chk("edge irqs", 16'(nb), 16'h2);
		rx.send(1'b0, 20);
		rx.send(1'b1, 20);
		rchk(IRT_A_SCTL, 8'ha7);
		chk("edge irqs", 16'(nb), 16'h4);
		close_out();
	end
endmodule
`default_nettype wire

// ===== irt_timer.sv
/*
 Infrared counter/timer pair: byte timer, word timer, shared edge
 detector with glitch filter, and a strobe register port.
 Assumes a synchronous processor-side port and inputs synchronous to clk.
*/
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module irt_timer
	import irt_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	input  wire logic       in_a,
	input  wire logic       in_b,
	input  wire logic       byte_port_out,
	input  wire logic       word_port_out,
	input  wire logic       comb_port_out,
	output logic            byte_pin,
	output logic            word_output_pin,
	output logic            comb_pin,
	output logic            byte_irq,
	output logic            word_irq
);
	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic [7:0]  bctl, sctl, wctl;
	logic [7:0]  byte_low_hold, byte_high_hold;
	logic [7:0]  word_hold_lower, word_hold_upper;
	logic [7:0]  byte_capture_low, byte_capture_high;
	logic [7:0]  word_capture_lower, word_capture_upper;
	logic [7:0]  bcnt;
	logic [15:0] wcnt;
	logic        byte_timer_output, word_timer_output;
	logic        b_started, w_started, w_armed;
	logic [2:0]  div;
	logic [4:0]  flt_cnt;
	logic        flt_in, flt_q;

	logic demod, pp, b_ce, w_ce, rise, fall, edg;
	logic wr_b, wr_s, wr_w, b_tc, w_tc, b_en, w_en;
	logic b_go, w_go, b_cap, w_cap, w_bcap, b_tev, w_tev;
	logic raw_in;
	logic [4:0] flt_w;

	// Clock enable for a divide code: 0,1,2,3 -> /1,/2,/4,/8
	function automatic logic div_tick(input logic [1:0] code,
		input logic [2:0] d);
		case (code)
			2'h0: div_tick = 1'b1;
			2'h1: div_tick = d[0];
			2'h2: div_tick = &d[1:0];
			default: div_tick = &d;
		endcase
	endfunction

	// ------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------
	assign demod = sctl[IRT_B_MODE];
	assign pp    = !demod && sctl[IRT_B_F2H:IRT_B_F2L] == IRT_SUB_PP;
	assign b_en  = bctl[IRT_B_EN];
	assign w_en  = wctl[IRT_B_EN];
	assign wr_b  = wr && addr == IRT_A_BCTL;
	assign wr_s  = wr && addr == IRT_A_SCTL;
	assign wr_w  = wr && addr == IRT_A_WCTL;
	assign b_ce  = div_tick(bctl[IRT_B_CLKH:IRT_B_CLKL], div);
	assign w_ce  = div_tick(wctl[IRT_B_CLKH:IRT_B_CLKL], div);
	// Terminal count is reaching one; the next tick shows zero unless a modulo-N run reloads its hold
	assign b_tc  = b_ce && b_started && bcnt == IRT_ONE8;
	assign w_tc  = w_ce && w_started && wcnt == IRT_ONE16;
	// Enable rising edge of software write starts a timer
	assign b_go  = wr_b && wdata[IRT_B_EN] && !b_en;
	assign w_go  = wr_w && wdata[IRT_B_EN] && !w_en;
	assign raw_in = sctl[IRT_B_INSEL] ? in_b : in_a;

	// ------------------------------------------------------------------
	// Glitch filter and edge detector
	// ------------------------------------------------------------------
	always_comb begin
		case (sctl[IRT_B_F2H:IRT_B_F2L])
			2'h1:    flt_w = IRT_FLT_4;
			2'h2:    flt_w = IRT_FLT_8;
			2'h3:    flt_w = IRT_FLT_16;
			default: flt_w = 5'h00;
		endcase
	end

	// Input must hold a new level for the filter width to be accepted
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flt_cnt <= 5'h00;
			flt_in  <= 1'b0;
			flt_q   <= 1'b0;
		end else begin
			flt_q <= flt_in;
			if (raw_in == flt_in)
				flt_cnt <= 5'h00;
			else if (flt_cnt + 5'h01 >= flt_w)
				flt_in <= raw_in;
			else
				flt_cnt <= flt_cnt + 5'h01;
		end
	end

	always_comb begin
		rise = demod && flt_in && !flt_q;
		fall = demod && !flt_in && flt_q;
		case (sctl[IRT_B_F1H:IRT_B_F1L])
			IRT_EDG_FALL: edg = fall;
			IRT_EDG_RISE: edg = rise;
			IRT_EDG_BOTH: edg = rise || fall;
			default:      edg = 1'b0;
		endcase
	end
	// Edge gating on a running timer: captures only after the first edge
	assign b_cap  = edg && b_en && b_started;
	assign w_cap  = edg && w_en && w_started && w_armed;
	assign w_bcap = demod && w_en && w_started && !w_armed
		&& b_tc && wctl[IRT_B_SUB];
	assign b_tev  = b_tc && (demod || bctl[IRT_B_SUB] || byte_timer_output);
	assign w_tev  = w_tc;

	// Shared clock prescaler; dividers reuse one free counter
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			div <= 3'h0;
		else
			div <= div + 3'h1;
	end

	// ------------------------------------------------------------------
	// Byte timer
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bctl <= IRT_RST8;
			bcnt <= IRT_RST8;
			b_started <= 1'b0;
			byte_timer_output <= 1'b0;
		end else begin
			if (wr_b) begin
				bctl[IRT_B_EN]  <= wdata[IRT_B_EN];
				bctl[IRT_B_SUB] <= wdata[IRT_B_SUB];
				bctl[4:0] <= wdata[4:0];
			end
			// Set wins over the write-one clear
			if (b_tev)
				bctl[IRT_B_TO] <= 1'b1;
			else if (wr_b && wdata[IRT_B_TO])
				bctl[IRT_B_TO] <= 1'b0;
			if (b_go || (pp && w_tc)) begin
				bctl[IRT_B_EN] <= 1'b1;
				byte_timer_output <= sctl[IRT_B_RISE];
				b_started <= !demod;
				bcnt <= sctl[IRT_B_RISE] ? byte_high_hold : byte_low_hold;
			end else if (!b_en) begin
				b_started <= 1'b0;
			end else if (demod) begin
				if (edg && !b_started) begin
					b_started <= 1'b1;
					bcnt <= IRT_FF8;
				end else if (b_cap) begin
					bcnt <= IRT_FF8;
				end else if (b_ce && b_started) begin
					bcnt <= bcnt - IRT_ONE8;
				end
			end else if (b_tc) begin
				byte_timer_output <= !byte_timer_output;
				if (bctl[IRT_B_SUB]) begin
					bctl[IRT_B_EN] <= 1'b0;
					bcnt <= IRT_RST8;
				end else begin
					bcnt <= byte_timer_output ? byte_low_hold
						: byte_high_hold;
				end
			end else if (b_ce && b_started) begin
				bcnt <= bcnt - IRT_ONE8;
			end
		end
	end

	// ------------------------------------------------------------------
	// Word timer
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wctl <= IRT_RST8;
			wcnt <= 16'h0000;
			w_started <= 1'b0;
			w_armed <= 1'b0;
			word_timer_output <= 1'b0;
		end else begin
			if (wr_w) begin
				wctl[IRT_B_EN] <= wdata[IRT_B_EN];
				wctl[IRT_B_SUB] <= wdata[IRT_B_SUB];
				wctl[4:0] <= wdata[4:0];
				if (wdata[IRT_B_SUB] && !wctl[IRT_B_SUB])
					w_armed <= 1'b1;
			end
			if (w_tev)
				wctl[IRT_B_TO] <= 1'b1;
			else if (wr_w && wdata[IRT_B_TO])
				wctl[IRT_B_TO] <= 1'b0;
			if (w_go || (pp && b_tc)) begin
				wctl[IRT_B_EN] <= 1'b1;
				word_timer_output <= sctl[IRT_B_FALL];
				w_started <= !demod;
				w_armed <= 1'b1;
				wcnt <= {word_hold_upper, word_hold_lower};
			end else if (!w_en) begin
				w_started <= 1'b0;
			end else if (demod) begin
				if (edg && !w_started) begin
					w_started <= 1'b1;
					wcnt <= IRT_FF16;
				end else if (w_cap) begin
					wcnt <= IRT_FF16;
					if (wctl[IRT_B_SUB])
						w_armed <= 1'b0;
				end else if (w_ce && w_started) begin
					wcnt <= wcnt - IRT_ONE16;
				end
			end else if (w_tc) begin
				word_timer_output <= !word_timer_output;
				if (wctl[IRT_B_SUB]) begin
					wctl[IRT_B_EN] <= 1'b0;
					wcnt <= 16'h0000;
				end else begin
					wcnt <= {word_hold_upper, word_hold_lower};
				end
			end else if (w_ce && w_started) begin
				wcnt <= wcnt - IRT_ONE16;
			end
		end
	end

	// ------------------------------------------------------------------
	// Shared control, holds and captures
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sctl <= IRT_RST8;
		end else if (demod && !(wr_s && !wdata[IRT_B_MODE])) begin
			if (wr_s)
				sctl[7:2] <= wdata[7:2];
			// Set wins over write-one clear
			if (rise)
				sctl[IRT_B_RISE] <= 1'b1;
			else if (wr_s && wdata[IRT_B_RISE])
				sctl[IRT_B_RISE] <= 1'b0;
			if (fall)
				sctl[IRT_B_FALL] <= 1'b1;
			else if (wr_s && wdata[IRT_B_FALL])
				sctl[IRT_B_FALL] <= 1'b0;
		end else if (wr_s) begin
			sctl <= wdata;
		end
	end

	// Holds: software may write at any moment, next load picks them up
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			byte_low_hold <= IRT_RST8;
			byte_high_hold <= IRT_RST8;
			word_hold_lower <= IRT_RST8;
			word_hold_upper <= IRT_RST8;
		end else if (wr) begin
			case (addr)
				IRT_A_BLO: byte_low_hold <= wdata;
				IRT_A_BHI: byte_high_hold <= wdata;
				IRT_A_WLO: word_hold_lower <= wdata;
				IRT_A_WHI: word_hold_upper <= wdata;
				default: ;
			endcase
		end
	end

	// Captures store the one's complement of the running count
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			byte_capture_low <= IRT_RST8;
			byte_capture_high <= IRT_RST8;
			word_capture_lower <= IRT_RST8;
			word_capture_upper <= IRT_RST8;
		end else begin
			if (b_cap && rise)
				byte_capture_low <= ~bcnt;
			else if (b_cap && fall)
				byte_capture_high <= ~bcnt;
			if (w_cap || w_bcap) begin
				word_capture_lower <= ~wcnt[7:0];
				word_capture_upper <= ~wcnt[15:8];
			end
		end
	end

	// ------------------------------------------------------------------
	// Read port, pins and requests
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= IRT_RST8;
		end else if (rd) begin
			case (addr)
				IRT_A_BCTL: rdata <= bctl;
				IRT_A_SCTL: rdata <= sctl;
				IRT_A_WCTL: rdata <= wctl;
				IRT_A_BLO:  rdata <= byte_low_hold;
				IRT_A_BHI:  rdata <= byte_high_hold;
				IRT_A_WLO:  rdata <= word_hold_lower;
				IRT_A_WHI:  rdata <= word_hold_upper;
				IRT_A_WCL:  rdata <= word_capture_lower;
				IRT_A_WCU:  rdata <= word_capture_upper;
				IRT_A_BCL:  rdata <= byte_capture_low;
				IRT_A_BCH:  rdata <= byte_capture_high;
				default:    rdata <= IRT_RST8;
			endcase
		end else begin
			rdata <= IRT_RST8;
		end
	end

	// Pin muxes are registered so outputs lag the timers by one cycle
	logic w_out_eff, b_out_eff;
	always_comb begin
		b_out_eff = b_en ? byte_timer_output : !sctl[IRT_B_RISE];
		if (!demod && sctl[IRT_B_F2H:IRT_B_F2L] == IRT_SUB_F0 - 2'h1)
			w_out_eff = 1'b0;
		else if (!demod && sctl[IRT_B_F2H:IRT_B_F2L] == IRT_SUB_F0)
			w_out_eff = 1'b1;
		else
			w_out_eff = w_en ? word_timer_output : !sctl[IRT_B_FALL];
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			byte_pin <= 1'b0;
			word_output_pin <= 1'b0;
			comb_pin <= 1'b0;
			byte_irq <= 1'b0;
			word_irq <= 1'b0;
		end else begin
			byte_pin <= bctl[IRT_B_PIN] ? b_out_eff : byte_port_out;
			word_output_pin <= wctl[IRT_B_PIN] ? w_out_eff
				: word_port_out;
			case ({demod || sctl[IRT_B_INSEL], sctl[IRT_B_F1H:IRT_B_F1L]})
				3'h0: comb_pin <= b_out_eff & w_out_eff;
				3'h1: comb_pin <= b_out_eff | w_out_eff;
				3'h2: comb_pin <= !(b_out_eff | w_out_eff);
				3'h3: comb_pin <= !(b_out_eff & w_out_eff);
				default: comb_pin <= comb_port_out;
			endcase
			byte_irq <= (b_tev && bctl[IRT_B_TIE])
				|| (b_cap && bctl[IRT_B_CIE]);
			word_irq <= (w_tev && wctl[IRT_B_TIE])
				|| ((w_cap || w_bcap) && wctl[IRT_B_CIE]);
		end
	end
endmodule
`default_nettype wire

// ===== irt_timer_checker.sv
/*
 Port-level assertions for the counter/timer pair, bound to irt_timer.
 Assumes one master owns the register port.
*/
`timescale 1ns/1ps
`default_nettype none
module irt_timer_checker
	import irt_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst_b,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	input wire logic       in_a,
	input wire logic       in_b,
	input wire logic       byte_port_out,
	input wire logic       word_port_out,
	input wire logic       comb_port_out,
	input wire logic       byte_pin,
	input wire logic       word_output_pin,
	input wire logic       comb_pin,
	input wire logic       byte_irq,
	input wire logic       word_irq
);
	// ----------------
	// Shadow of control bits
	// ----------------
	logic [7:0] s_ctl;
	logic [2:0] w_ctl;
	logic       b_pin;
	logic       up;

	// Flags are not mirrored, so only software-owned bits are used
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_ctl <= 8'h00;
			w_ctl <= 3'h0;
			b_pin <= 1'b0;
			up    <= 1'b0;
		end else begin
			up <= 1'b1;
			if (wr && addr == IRT_A_SCTL) s_ctl <= wdata;
			if (wr && addr == IRT_A_WCTL) w_ctl <= wdata[2:0];
			if (wr && addr == IRT_A_BCTL) b_pin <= wdata[0];
		end
	end

	// ----------------
	// Properties
	// ----------------
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	sequence w_go;
		wr && addr == IRT_A_WCTL && wdata[7] && wdata[0];
	endsequence
	sequence b_go;
		wr && addr == IRT_A_BCTL && wdata[7] && wdata[0];
	endsequence
	sequence tx_norm;
		!s_ctl[7] && s_ctl[3:2] == IRT_SUB_NORM;
	endsequence

	chk_word_route: assert property (
		up && !w_ctl[0] |=> word_output_pin == $past(word_port_out))
		else $error("word pin not showing port value");
	chk_word_start: assert property (
		w_go ##0 tx_norm |=> ##1 word_output_pin == s_ctl[0])
		else $error("word output not at initial level");
	chk_word_idle: assert property (
		wr && addr == IRT_A_WCTL && wdata == 8'h01 ##0 tx_norm
		|=> ##1 word_output_pin == !s_ctl[0])
		else $error("idle word output not inverted");
	chk_word_toggle: assert property (
		word_irq && !s_ctl[7] && w_ctl[0]
		|=> word_output_pin != $past(word_output_pin))
		else $error("word output did not toggle at timeout");
	chk_byte_start: assert property (
		b_go ##0 !s_ctl[7] |=> ##1 byte_pin == s_ctl[1])
		else $error("byte output not at initial level");
	chk_byte_toggle: assert property (
		byte_irq && !s_ctl[7] && b_pin |=> byte_pin != $past(byte_pin))
		else $error("byte output did not toggle at timeout");
	chk_word_mask: assert property (
		word_irq |-> w_ctl[1] || w_ctl[2])
		else $error("word request while both masks clear");
	chk_word_pulse: assert property (
		word_irq |=> !word_irq)
		else $error("word request longer than one cycle");
	chk_byte_pulse: assert property (
		byte_irq |=> !byte_irq)
		else $error("byte request longer than one cycle");
	// Pins register together, so the combined pin matches both routed pins
	chk_comb_and: assert property (
		up && !s_ctl[7] && s_ctl[6:4] == 3'h0 && b_pin && w_ctl[0]
		|=> comb_pin == (byte_pin && word_output_pin))
		else $error("combined pin is not the AND of both outputs");
	chk_comb_route: assert property (
		up && (s_ctl[7] || s_ctl[6]) |=> comb_pin == $past(comb_port_out))
		else $error("combined pin not showing port value");
endmodule

bind irt_timer irt_timer_checker chk (
	.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
	.rd(rd), .rdata(rdata), .in_a(in_a), .in_b(in_b),
	.byte_port_out(byte_port_out), .word_port_out(word_port_out),
	.comb_port_out(comb_port_out), .byte_pin(byte_pin),
	.word_output_pin(word_output_pin), .comb_pin(comb_pin),
	.byte_irq(byte_irq), .word_irq(word_irq));
`default_nettype wire
